// [design/isp_pkg.sv]
// Purpose: constants of the interrupt source front end
// Assumes: 32-bit APB word registers, one 125 MHz clock
// Notes:   offsets are byte addresses; vectors are 8-bit codes
//
// Contract
// - four-bit priority fields, binary, reset zero
// - seventeen levels ranked zero to sixteen
// - priority zero source is never forwarded
// - pin non-maskable level sixteen, always accepted
// - non-maskable pin edge, one select bit
// - non-maskable accept loads mask fifteen
// - per pin sense bit plus edge field
// - each request pin has own priority
// - low mode request follows pin low
// - low mode flag reads current request
// - falling mode raises on high to low
// - edge detection latched until accepted
// - read one then write zero clears
// - pin accept loads its priority mask
// - each peripheral source has distinct vector
// - each peripheral has own priority field
// - peripheral accept loads its priority mask
// - equal priority: smaller vector served first
package isp_pkg;
  ////////////////////////////////////////////////////////////////////////////
  localparam int          NPIN        = 4;        // request pins
  localparam int          NPER        = 4;        // peripheral lines
  localparam int          NSRC        = NPIN + NPER;
  localparam int          PRIO_W      = 4;        // field width
  localparam int          LVL_W       = 5;        // seventeen-level scale
  localparam logic [4:0]  LVL_NMI     = 5'h10;    // level sixteen
  localparam logic [3:0]  MASK_NMI    = 4'hf;     // mask loaded by nmi
  localparam logic [3:0]  PRIO_RST    = 4'h0;
  ////////////////////////////////////////////////////////////////////////////
  // register byte offsets
  localparam logic [7:0]  OFS_CTRL_ONE = 8'h00;   // irq_ctrl_one
  localparam logic [7:0]  OFS_EDGE_TWO = 8'h04;   // pin_edge_ctrl_two
  localparam logic [7:0]  OFS_STATUS   = 8'h08;   // pin_request_status
  localparam logic [7:0]  OFS_PRIO_A   = 8'h0c;   // priority_bank_a
  localparam logic [7:0]  OFS_PRIO_B   = 8'h10;   // peripheral priority bank
  // field positions
  localparam int          NMI_SEL_BIT  = 8;       // nonmaskable_edge_select
  localparam int          SENSE_LSB    = 0;       // pin_sense_select[3:0]
  localparam logic [1:0]  EDGE_RISE    = 2'h1;    // pin_edge_select code
  localparam logic [1:0]  EDGE_FALL    = 2'h0;    // any other code falls too
  localparam logic [15:0] BANK_RST     = 16'h0000;
  ////////////////////////////////////////////////////////////////////////////
  // vector numbers
  localparam logic [7:0]  VEC_NMI      = 8'h0b;
  localparam logic [7:0]  VEC_PIN_BASE = 8'h40;
  localparam logic [7:0]  VEC_PER_BASE = 8'h58;
  localparam logic [7:0]  VEC_PER_STEP = 8'h04;
endpackage

// [design/isp_top.sv]
// Purpose: pin and peripheral interrupt detection, priority, request
// Assumes: core samples int_request/int_vector, pulses core_accept
// Notes:   pins pass two flops; peripheral lines are same-clock levels
`timescale 1ns/1ps
module isp_top
  import isp_pkg::*;
(
  // clock and reset
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  // apb slave
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [7:0]           paddr,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  // pins
  input  wire logic                 nmi_pin,
  input  wire logic [isp_pkg::NPIN-1:0] irq_pin_n,
  // peripheral request lines
  input  wire logic [isp_pkg::NPER-1:0] periph_req,
  // core side
  input  wire logic [3:0]           processor_mask_level,
  input  wire logic                 core_accept,
  output logic                      int_request,
  output logic      [7:0]           int_vector,
  output logic      [3:0]           int_new_mask
);
  import isp_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // registers
  logic             nonmaskable_edge_select; // 1 = rising edge
  logic [NPIN-1:0]  pin_sense_select;        // 0 = low level, 1 = edge
  logic [7:0]       pin_edge_select;         // two bits per pin
  logic [15:0]      priority_bank_a;         // pin priorities, pin0 on top
  logic [15:0]      priority_bank_b;         // peripheral priorities
  logic [NPIN-1:0]  edge_flag;               // latched edge detections
  logic [NPIN-1:0]  flag_armed;              // flag was read as one
  logic             nmi_pend;                // latched nmi edge

  // synchronisers: stage one only feeds stage two
  logic             nmi_s1;
  logic             nmi_s2;
  logic             nmi_s3;                  // previous sample
  logic [NPIN-1:0]  irq_s1;
  logic [NPIN-1:0]  irq_s2;
  logic [NPIN-1:0]  irq_s3;

  // decoded bus phases
  logic             acc_done;                // access phase completes
  logic             wr_done;
  logic             rd_done;

  // detection terms
  logic             nmi_edge;
  logic [NPIN-1:0]  pin_fall;
  logic [NPIN-1:0]  pin_rise;
  logic [NPIN-1:0]  pin_edge_hit;
  logic [NPIN-1:0]  pin_level;               // low-level requests
  logic [NPIN-1:0]  pin_req;                 // requests seen by arbiter
  logic [NPIN-1:0]  status_view;             // value read from status
  logic [NPIN-1:0]  flag_clear;
  logic [NPIN-1:0]  pin_taken;               // accepted this cycle

  // arbiter results
  logic             next_request;
  logic [7:0]       next_vector;
  logic [3:0]       next_mask;

  ////////////////////////////////////////////////////////////////////////////
  // bus phase decode; pready is raised by the setup cycle so every
  // access takes exactly one access cycle
  assign acc_done = psel && penable && pready;
  assign wr_done  = acc_done && pwrite;
  assign rd_done  = acc_done && !pwrite;

  // pin synchronisers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nmi_s1 <= 1'b0;
      nmi_s2 <= 1'b0;
      nmi_s3 <= 1'b0;
      irq_s1 <= '1;       // request pins idle high
      irq_s2 <= '1;
      irq_s3 <= '1;
    end else begin
      nmi_s1 <= nmi_pin;
      nmi_s2 <= nmi_s1;
      nmi_s3 <= nmi_s2;
      irq_s1 <= irq_pin_n;
      irq_s2 <= irq_s1;
      irq_s3 <= irq_s2;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // edge and level detection
  always_comb begin
    nmi_edge = nonmaskable_edge_select ? (nmi_s2 && !nmi_s3)
                                       : (!nmi_s2 && nmi_s3);
    for (int i = 0; i < NPIN; i++) begin
      pin_fall[i]     = irq_s3[i] && !irq_s2[i];
      pin_rise[i]     = !irq_s3[i] && irq_s2[i];
      // sense bit and edge field pick the mode
      pin_edge_hit[i] = pin_sense_select[i] &&
                        ((pin_edge_select[2*i +: 2] == EDGE_RISE) ? pin_rise[i]
                                                                  : pin_fall[i]);
      pin_level[i]    = !pin_sense_select[i] && !irq_s2[i];
      pin_req[i]      = pin_sense_select[i] ? edge_flag[i] : pin_level[i];
      status_view[i]  = pin_sense_select[i] ? edge_flag[i] : pin_level[i];
      flag_clear[i]   = wr_done && (paddr == OFS_STATUS) &&
                        !pwdata[i] && flag_armed[i];
      pin_taken[i]    = core_accept && int_request &&
                        (int_vector == VEC_PIN_BASE + 8'(i));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // latched edge flags; a new edge wins over a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      edge_flag  <= '0;
      flag_armed <= '0;
    end else begin
      for (int i = 0; i < NPIN; i++) begin
        if (pin_edge_hit[i]) begin
          edge_flag[i] <= 1'b1;
        end else if (flag_clear[i] || pin_taken[i]) begin
          edge_flag[i] <= 1'b0;
        end
        // arm only when software saw the flag set
        if (rd_done && (paddr == OFS_STATUS) && status_view[i]) begin
          flag_armed[i] <= 1'b1;
        end else if (flag_clear[i] || !edge_flag[i]) begin
          flag_armed[i] <= 1'b0;
        end
      end
    end
  end

  // nmi pending, held until the core takes it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nmi_pend <= 1'b0;
    end else if (nmi_edge) begin
      nmi_pend <= 1'b1;
    end else if (core_accept && int_request && int_vector == VEC_NMI) begin
      nmi_pend <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control register writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nonmaskable_edge_select <= 1'b0;
      pin_sense_select        <= '0;
      pin_edge_select         <= '0;
      priority_bank_a         <= BANK_RST;
      priority_bank_b         <= BANK_RST;
    end else if (wr_done) begin
      unique case (paddr)
        OFS_CTRL_ONE: begin
          nonmaskable_edge_select <= pwdata[NMI_SEL_BIT];
          pin_sense_select        <= pwdata[SENSE_LSB +: NPIN];
        end
        OFS_EDGE_TWO: pin_edge_select <= pwdata[7:0];
        OFS_PRIO_A:   priority_bank_a <= pwdata[15:0];
        OFS_PRIO_B:   priority_bank_b <= pwdata[15:0];
        default: ;    // status handled above, others ignored
      endcase
    end
  end

  // read data, ready and error are prepared in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= '0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= 1'b0;
      prdata  <= '0;
      if (psel && !penable) begin
        unique case (paddr)
          OFS_CTRL_ONE: prdata <= {23'h0, nonmaskable_edge_select, 4'h0,
                                   pin_sense_select};
          OFS_EDGE_TWO: prdata <= {24'h0, pin_edge_select};
          OFS_STATUS:   prdata <= {28'h0, status_view};
          OFS_PRIO_A:   prdata <= {16'h0, priority_bank_a};
          OFS_PRIO_B:   prdata <= {16'h0, priority_bank_b};
          default:      pslverr <= 1'b1;   // unmapped address
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // arbiter: scan sources in rising vector order and replace the winner
  // only on a strictly higher level, so ties go to the smaller vector
  always_comb begin
    logic [LVL_W-1:0] best_lvl;
    logic [3:0]       prio;
    logic             req;
    logic [7:0]       vec;
    best_lvl     = '0;
    prio         = '0;
    req          = 1'b0;
    vec          = '0;
    next_request = 1'b0;
    next_vector  = '0;
    next_mask    = '0;
    for (int s = 0; s < NSRC; s++) begin
      if (s < NPIN) begin
        req  = pin_req[s];
        prio = priority_bank_a[15 - 4*s -: 4];
        vec  = VEC_PIN_BASE + 8'(s);
      end else begin
        req  = periph_req[s - NPIN];
        prio = priority_bank_b[15 - 4*(s - NPIN) -: 4];
        vec  = VEC_PER_BASE + 8'(s - NPIN) * VEC_PER_STEP;
      end
      // zero masks; level must exceed current core mask
      if (req && prio != PRIO_RST && prio > processor_mask_level &&
          {1'b0, prio} > best_lvl) begin
        best_lvl     = {1'b0, prio};
        next_request = 1'b1;
        next_vector  = vec;
        next_mask    = prio;
      end
    end
    // nmi outranks all at level sixteen, ignoring the core mask
    if (nmi_pend) begin
      best_lvl     = LVL_NMI;
      next_request = 1'b1;
      next_vector  = VEC_NMI;
      next_mask    = MASK_NMI;
    end
  end

  // registered request to the core
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_request  <= 1'b0;
      int_vector   <= '0;
      int_new_mask <= '0;
    end else begin
      int_request  <= next_request;
      int_vector   <= next_vector;
      int_new_mask <= next_mask;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_nmi_taken;
    core_accept && int_request && int_vector == VEC_NMI;
  endsequence

  a_zero_masked: assert property (
    int_request && int_vector != VEC_NMI |-> int_new_mask != 4'h0)
    else $error("request forwarded with priority zero");

  a_nmi_always: assert property (
    nmi_pend |=> int_request && int_vector == VEC_NMI)
    else $error("pending nmi not presented");

  a_nmi_edge_latch: assert property (
    nonmaskable_edge_select && nmi_s2 && !nmi_s3 |=> nmi_pend)
    else $error("nmi rising edge missed");

  a_nmi_mask_fifteen: assert property (
    int_request && int_vector == VEC_NMI |-> int_new_mask == 4'hf)
    else $error("nmi mask not fifteen");

  // judged against the pin two samples back, so a broken sync chain shows
  a_level_follow: assert property (
    !pin_sense_select[0] && $past(!pin_sense_select[0]) && $past(presetn, 2) |->
      pin_req[0] == !$past(irq_pin_n[0], 2))
    else $error("low level request not following pin");

  a_fall_latch: assert property (
    pin_sense_select[0] && pin_edge_select[1:0] != EDGE_RISE &&
    irq_s3[0] && !irq_s2[0] |=> edge_flag[0])
    else $error("falling edge not latched");

  a_flag_hold: assert property (
    edge_flag[0] && !flag_clear[0] && !pin_taken[0] |=> edge_flag[0])
    else $error("edge flag lost");

  a_flag_clear: assert property (
    flag_clear[0] && !pin_edge_hit[0] |=> !edge_flag[0] ##1 !int_request ||
      int_vector != VEC_PIN_BASE || pin_edge_hit[0] || !pin_sense_select[0])
    else $error("cleared flag still pending");

  a_pin_mask: assert property (
    int_request && int_vector == VEC_PIN_BASE |->
      int_new_mask == $past(priority_bank_a[15:12]))
    else $error("pin mask differs from priority");

  a_above_mask: assert property (
    int_request && int_vector != VEC_NMI |->
      int_new_mask > $past(processor_mask_level))
    else $error("request not above core mask");

  a_nmi_clears: assert property (
    s_nmi_taken and !nmi_edge |=> !nmi_pend)
    else $error("accepted nmi stays pending");

  ////////////////////////////////////////////////////////////////////////////
  // per-pin checks watch one pin each; the detection logic is one loop,
  // so a fault in it shows on every pin alike
  sequence s_pin2_rise;
    pin_sense_select[2] && pin_edge_select[5:4] == EDGE_RISE &&
    !irq_s3[2] && irq_s2[2];
  endsequence

  a_rise_latch: assert property (
    s_pin2_rise |=> edge_flag[2])
    else $error("rising edge not latched");

  a_nmi_fall_latch: assert property (
    !nonmaskable_edge_select && !nmi_s2 && nmi_s3 |=> nmi_pend)
    else $error("nmi falling edge missed");

  // read data was prepared in the setup cycle, hence the past values
  a_status_level: assert property (
    rd_done && paddr == OFS_STATUS && $past(!pin_sense_select[0]) |->
      prdata[0] == $past(!irq_s2[0]))
    else $error("status flag not request level");

  a_tie_order: assert property (
    periph_req[1:0] == 2'b11 && priority_bank_b[15:12] == priority_bank_b[11:8] |->
      next_vector != VEC_PER_BASE + VEC_PER_STEP)
    else $error("equal priority tie not to smaller vector");

  a_bank_reset: assert property (
    $rose(presetn) |-> priority_bank_a == BANK_RST && priority_bank_b == BANK_RST)
    else $error("priority fields not zero after reset");

endmodule

// [verification/isp_core_model.sv]
// Purpose: behavioural core side: holds mask level, accepts requests
// Assumes: one accept per raise of accept_en, after acc_delay cycles
// Notes:   accepting loads the presented new mask, as a real core does
`timescale 1ns/1ps
module isp_core_model (
  // clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // request from the front end
  input  wire logic       int_request,
  input  wire logic [7:0] int_vector,
  input  wire logic [3:0] int_new_mask,
  // bench controls
  input  wire logic       accept_en,
  input  wire logic [3:0] acc_delay,
  input  wire logic       mask_wr,
  input  wire logic [3:0] mask_val,
  // core outputs
  output logic      [3:0] processor_mask_level,
  output logic            core_accept,
  output logic      [7:0] acc_vec,
  output logic      [3:0] acc_mask
);
  logic [3:0] wait_cnt; // cycles seen with a request
  logic       done;     // one accept per enable, avoids re-taking a dying request
  ////////////////////////////////////////////////////////////////////////////
  // accept sequencing and mask load
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      processor_mask_level <= 4'h0;
      core_accept          <= 1'b0;
      acc_vec              <= 8'h00;
      acc_mask             <= 4'h0;
      wait_cnt             <= 4'h0;
      done                 <= 1'b0;
    end else begin
      core_accept <= 1'b0;
      if (mask_wr) begin
        processor_mask_level <= mask_val;
      end
      if (!accept_en) begin
        done     <= 1'b0;
        wait_cnt <= 4'h0;
      end else if (int_request && !done) begin
        if (wait_cnt >= acc_delay) begin
          core_accept          <= 1'b1;
          done                 <= 1'b1;
          acc_vec              <= int_vector;
          acc_mask             <= int_new_mask;
          processor_mask_level <= int_new_mask;
        end else begin
          wait_cnt <= wait_cnt + 4'h1;
        end
      end
    end
  end
endmodule

// [verification/isp_top_tb_top.sv]
// Purpose: self-checking bench of the interrupt source front end
// Assumes: apb answers within a few cycles; pins pass two flops
// Notes:   pins and peripheral lines are driven here, core by the model
`timescale 1ns/1ps
module isp_top_tb_top;
  import isp_pkg::*;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, int_request, core_accept, err;
  logic [7:0]  int_vector, acc_vec;
  logic [3:0]  int_new_mask, processor_mask_level, acc_mask;
  logic        nmi_pin = 0, accept_en = 0, mask_wr = 0;
  logic [3:0]  irq_pin_n = 4'hf, periph_req = 4'h0, acc_delay = 4'h0, mask_val = 4'h0;
  int          mismatches = 0, num_checks = 0;
  always #4 pclk = ~pclk;
  isp_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .nmi_pin(nmi_pin), .irq_pin_n(irq_pin_n), .periph_req(periph_req),
    .processor_mask_level(processor_mask_level), .core_accept(core_accept),
    .int_request(int_request), .int_vector(int_vector), .int_new_mask(int_new_mask));
  isp_core_model i_core (.pclk(pclk), .presetn(presetn), .int_request(int_request),
    .int_vector(int_vector), .int_new_mask(int_new_mask), .accept_en(accept_en),
    .acc_delay(acc_delay), .mask_wr(mask_wr), .mask_val(mask_val),
    .processor_mask_level(processor_mask_level), .core_accept(core_accept),
    .acc_vec(acc_vec), .acc_mask(acc_mask));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // one apb transfer; holds the request until pready is sampled high
  // no cycle count is assumed; only the watchdog ends a stuck wait
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task automatic setm(input logic [3:0] m);
    @(posedge pclk);
    mask_wr <= 1'b1; mask_val <= m;
    @(posedge pclk);
    mask_wr <= 1'b0;
  endtask
  // bounded wait, then the whole presented request is compared
  task automatic see_req(input logic [7:0] v, input logic [3:0] m);
    int n;
    n = 0;
    while (int_request !== 1'b1 && n < 12) begin
      @(posedge pclk);
      n++;
    end
    #1 chk({19'h0, int_request, int_vector, int_new_mask}, {19'h0, 1'b1, v, m});
    @(posedge pclk);
  endtask
  task automatic no_req();
    repeat (6) @(posedge pclk);
    #1 chk({31'h0, int_request}, 32'h0);
    @(posedge pclk);
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    apb(1'b0, OFS_PRIO_A, 32'h0); chk(rd, 32'h0);
    apb(1'b1, OFS_PRIO_A, 32'h5370);
    apb(1'b0, OFS_PRIO_A, 32'h0); chk(rd, 32'h5370);
    apb(1'b1, OFS_PRIO_B, 32'h7709);
    apb(1'b0, OFS_PRIO_B, 32'h0); chk(rd, 32'h7709);
    apb(1'b0, 8'h14, 32'h0); chk({err, rd[30:0]}, 32'h80000000);
    apb(1'b1, OFS_CTRL_ONE, 32'h106);
    apb(1'b1, OFS_EDGE_TWO, 32'h10);
  endtask
  task automatic t_nmi();
    setm(4'hf);
    @(posedge pclk);
    nmi_pin <= 1'b1; accept_en <= 1'b1; acc_delay <= 4'h3;
    see_req(VEC_NMI, MASK_NMI);
    repeat (8) @(posedge pclk);
    chk({acc_vec, acc_mask}, {20'h0, VEC_NMI, MASK_NMI});
    nmi_pin <= 1'b0; accept_en <= 1'b0;
    no_req();
    setm(4'h0);
  endtask
  task automatic t_level();
    irq_pin_n <= 4'b0110;
    see_req(VEC_PIN_BASE, 4'h5);
    apb(1'b0, OFS_STATUS, 32'h0); chk(rd, 32'h9);
    irq_pin_n[0] <= 1'b1;
    no_req();
    irq_pin_n[3] <= 1'b1;
    repeat (4) @(posedge pclk);
    apb(1'b0, OFS_STATUS, 32'h0); chk(rd, 32'h0);
  endtask
  task automatic t_fall();
    irq_pin_n[1] <= 1'b0;
    repeat (2) @(posedge pclk);
    irq_pin_n[1] <= 1'b1;
    see_req(8'h41, 4'h3);
    apb(1'b0, OFS_STATUS, 32'h0); chk(rd, 32'h2);
    apb(1'b1, OFS_STATUS, 32'h0);
    no_req();
    irq_pin_n[1] <= 1'b0;
    repeat (2) @(posedge pclk);
    irq_pin_n[1] <= 1'b1; accept_en <= 1'b1; acc_delay <= 4'h0;
    repeat (12) @(posedge pclk);
    chk({acc_vec, acc_mask}, 32'h413);
    apb(1'b0, OFS_STATUS, 32'h0); chk(rd, 32'h0);
    accept_en <= 1'b0;
    setm(4'h0);
  endtask
  task automatic t_rise();
    irq_pin_n[2] <= 1'b0;
    no_req();
    irq_pin_n[2] <= 1'b1;
    see_req(8'h42, 4'h7);
    apb(1'b0, OFS_STATUS, 32'h0); chk(rd, 32'h4);
    apb(1'b1, OFS_STATUS, 32'h0);
    no_req();
  endtask
  task automatic t_periph();
    periph_req <= 4'b0011;
    see_req(VEC_PER_BASE, 4'h7);
    periph_req <= 4'b0010;
    repeat (3) @(posedge pclk);
    see_req(8'h5c, 4'h7);
    periph_req <= 4'b1110;
    repeat (3) @(posedge pclk);
    see_req(8'h64, 4'h9);
    setm(4'h9);
    no_req();
    periph_req <= 4'h0;
  endtask
  // nmi on its falling edge; pin0 falls on the spare edge code
  task automatic t_mode();
    setm(4'h0);
    apb(1'b1, OFS_CTRL_ONE, 32'h9);
    apb(1'b1, OFS_EDGE_TWO, 32'h2);
    nmi_pin <= 1'b1;
    no_req();
    nmi_pin <= 1'b0;
    see_req(VEC_NMI, MASK_NMI);
    accept_en <= 1'b1; acc_delay <= 4'h0;
    repeat (6) @(posedge pclk);
    chk({acc_vec, acc_mask}, {20'h0, VEC_NMI, MASK_NMI});
    accept_en <= 1'b0;
    setm(4'h0);
    irq_pin_n[0] <= 1'b0;
    see_req(VEC_PIN_BASE, 4'h5);
    irq_pin_n[0] <= 1'b1;
    apb(1'b1, OFS_STATUS, 32'h0);
    see_req(VEC_PIN_BASE, 4'h5);
    apb(1'b0, OFS_STATUS, 32'h0); chk(rd, 32'h1);
    apb(1'b1, OFS_STATUS, 32'h0);
    no_req();
  endtask
  // a reset in mid-run returns the peripheral priority bank and irq_ctrl_one to zero
  task automatic t_reset();
    apb(1'b1, OFS_PRIO_B, 32'h1234);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, OFS_PRIO_B, 32'h0); chk(rd, 32'h0);
    apb(1'b0, OFS_CTRL_ONE, 32'h0); chk(rd, 32'h0);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_nmi();
    t_level();
    t_fall();
    t_rise();
    t_periph();
    t_mode();
    t_reset();
    give_verdict();
  end
  // hang guard, far beyond the few hundred cycles the run needs
  initial begin
    repeat (20000) @(posedge pclk);
    mismatches++;
    give_verdict();
  end
endmodule
